// ### verilog/i2c_master_defs.vh
// Constants for the I2C master engine
`ifndef I2C_MASTER_DEFS_VH
`define I2C_MASTER_DEFS_VH
// Control register two bit positions
`define CR2_START_BIT   0
`define CR2_RSTART_BIT  1
`define CR2_STOP_BIT    2
`define CR2_RECV_BIT    3
`define CR2_ACKSEQ_BIT  4
`define CR2_ACKDT_BIT   5
`define CR2_ACK_RECEIVED_FLAG_BIT 6
`define CR2_LOW_MASK    5'h1f
// Status register bit positions
`define STAT_BUF_FULL_BIT 0
`define STAT_STOP_BIT     2
`define STAT_START_BIT    3
// Reload field width and reset
`define RELOAD_W        7
`define RELOAD_RESET    7'h00
// Last phase index of an instruction cycle (4 phases, one clock each)
`define PHASES_PER_CYCLE 2'h3
// Fifo depth
`define FIFO_DEPTH      4
`endif

// ### verilog/i2c_master_fifo.v
// Small valid/ready FIFO for transmit bytes
`timescale 1ns/1ns
module i2c_master_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // Clock and reset
   input  wire             clk,
   input  wire             rst_n,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem[rd_q];
   // Pointer and count update
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
         if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
         case ({in_valid && in_ready, out_valid && out_ready})
            2'b10:   cnt_q <= cnt_q + 1'b1;
            2'b01:   cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end
   // Storage write
   always @(posedge clk) begin
      if (in_valid && in_ready) mem[wr_q] <= in_data;
   end
endmodule // i2c_master_fifo

// ### verilog/i2c_master_start_and_baud.v
// I2C master engine: start/stop generation, byte shifting, bit-period counter
`timescale 1ns/1ns
`include "i2c_master_defs.vh"
module i2c_master_start_and_baud #(
   parameter DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input  wire                 clk,
   input  wire                 arst_n,
   // Configuration
   input  wire [`RELOAD_W-1:0] reload_value_reg,
   // Control register two writes (low five bits request, ack data)
   input  wire                 cr2_we,
   input  wire [7:0]           cr2_wdata,
   output wire [7:0]           control_reg_two,
   // Transfer buffer writes through FIFO
   input  wire                 buf_we,
   input  wire [7:0]           buf_wdata,
   output wire                 buf_ready,
   // Received data
   output reg  [7:0]           rx_data,
   output reg                  rx_valid,
   // Status
   output wire [7:0]           port_status_reg,
   output reg                  port_irq_flag,
   input  wire                 port_irq_clr,
   output reg                  bus_collision_irq_flag,
   input  wire                 bus_collision_clr,
   output reg                  write_collision_flag,
   input  wire                 write_collision_clr,
   // Bus pins
   input  wire                 scl_in,
   output wire                 scl_out,
   output wire                 scl_oe,
   input  wire                 sda_in,
   output wire                 sda_out,
   output wire                 sda_oe
);
   ////////////////////////////////////////////////////////////////////////////
   localparam ST_IDLE  = 4'h0;
   localparam ST_SCHK  = 4'h1;
   localparam ST_SLOW  = 4'h2;
   localparam ST_SHOLD = 4'h3;
   localparam ST_BLOW  = 4'h4;
   localparam ST_BHIGH = 4'h5;
   localparam ST_RSREL = 4'h6;
   localparam ST_RSHI  = 4'h7;
   localparam ST_PLOW  = 4'h8;
   localparam ST_PHIGH = 4'h9;
   localparam ST_PDONE = 4'ha;
   localparam OP_TX  = 2'h0;
   localparam OP_RX  = 2'h1;
   localparam OP_ACK = 2'h2;

   // Reset release through two flops
   reg rs1_q, rst_n;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end

   // Pin synchronisers
   reg scl_m_q, scl_s_q, sda_m_q, sda_s_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_m_q <= 1'b1;
         scl_s_q <= 1'b1;
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         scl_m_q <= scl_in;
         scl_s_q <= scl_m_q;
         sda_m_q <= sda_in;
         sda_s_q <= sda_m_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase divider: four clocks per instruction cycle, tick on phase 2 and 4
   reg [1:0] ph_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) ph_q <= 2'h0;
      else        ph_q <= (ph_q == `PHASES_PER_CYCLE) ? 2'h0 : ph_q + 2'h1;
   end
   wire tick = ph_q[0];

   ////////////////////////////////////////////////////////////////////////////
   reg [3:0]           st_q;
   reg [1:0]           op_q;
   reg [`RELOAD_W-1:0] brg_q;
   reg                 brg_run_q;
   reg [7:0]           sh_q;
   reg [3:0]           bit_q;
   reg                 scl_low_q, sda_low_q;
   reg                 start_q, rstart_q, stop_q, recv_q, ackseq_q, ackdt_q;
   reg                 ack_received_flag_q, s_bit_q, p_bit_q;
   wire                brg_zero = (brg_q == {`RELOAD_W{1'b0}});
   wire                timeout  = brg_run_q && brg_zero && tick;
   wire                busy     = (st_q != ST_IDLE) && (st_q != ST_PDONE);
   wire                in_start = (st_q == ST_SCHK) || (st_q == ST_SLOW) || start_q ||
                                  (st_q == ST_RSREL) || (st_q == ST_RSHI) || rstart_q;

   // FIFO in front of the shift register; only drains when engine idle
   wire       f_valid;
   wire [7:0] f_data;
   wire       f_take = f_valid && (st_q == ST_IDLE) && !start_q && !rstart_q &&
                       !stop_q && !recv_q && !ackseq_q;
   wire       f_in_ready;
   i2c_master_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(2)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (buf_we && !in_start),
      .in_ready  (f_in_ready),
      .in_data   (buf_wdata),
      .out_valid (f_valid),
      .out_ready (f_take),
      .out_data  (f_data)
   );
   assign buf_ready = f_in_ready && !in_start;

   assign control_reg_two = {1'b0, ack_received_flag_q, ackdt_q, ackseq_q, recv_q, stop_q,
                             rstart_q, start_q};
   assign port_status_reg = {4'h0, s_bit_q, p_bit_q, 1'b0, f_valid};

   // Drive low or release only
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_low_q;
   assign sda_oe  = sda_low_q;

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         op_q <= OP_TX;
         brg_q <= `RELOAD_RESET;
         brg_run_q <= 1'b0;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         start_q <= 1'b0;
         rstart_q <= 1'b0;
         stop_q <= 1'b0;
         recv_q <= 1'b0;
         ackseq_q <= 1'b0;
         ackdt_q <= 1'b0;
         ack_received_flag_q <= 1'b0;
         s_bit_q <= 1'b0;
         p_bit_q <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         port_irq_flag <= 1'b0;
         bus_collision_irq_flag <= 1'b0;
         write_collision_flag <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         // Flag clears; sets below win
         if (port_irq_clr)        port_irq_flag <= 1'b0;
         if (bus_collision_clr)   bus_collision_irq_flag <= 1'b0;
         if (write_collision_clr) write_collision_flag <= 1'b0;
         // Write collision on blocked buffer write
         if (buf_we && (in_start || !f_in_ready)) write_collision_flag <= 1'b1;
         // Request bits; low five locked while busy
         if (cr2_we) begin
            ackdt_q <= cr2_wdata[`CR2_ACKDT_BIT];
            if (!busy && !in_start && !f_valid) begin
               start_q  <= cr2_wdata[`CR2_START_BIT];
               rstart_q <= cr2_wdata[`CR2_RSTART_BIT];
               stop_q   <= cr2_wdata[`CR2_STOP_BIT];
               recv_q   <= cr2_wdata[`CR2_RECV_BIT];
               ackseq_q <= cr2_wdata[`CR2_ACKSEQ_BIT];
            end
         end
         // Counter: count down to zero, then halt
         if (brg_run_q && tick && !brg_zero) brg_q <= brg_q - 1'b1;
         case (st_q)
            ST_IDLE: begin
               brg_run_q <= 1'b0;
               if (start_q) begin
                  if (!scl_s_q || !sda_s_q) begin
                     bus_collision_irq_flag <= 1'b1;
                     start_q <= 1'b0;
                  end else begin
                     brg_q <= reload_value_reg;
                     brg_run_q <= 1'b1;
                     st_q <= ST_SCHK;
                  end
               end else if (rstart_q) begin
                  scl_low_q <= 1'b1;
                  sda_low_q <= 1'b0;
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
                  st_q <= ST_RSREL;
               end else if (stop_q) begin
                  scl_low_q <= 1'b1;
                  sda_low_q <= 1'b1;
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
                  st_q <= ST_PLOW;
               end else if (f_take || recv_q || ackseq_q) begin
                  op_q <= f_take ? OP_TX : (recv_q ? OP_RX : OP_ACK);
                  sh_q <= f_data; // address byte carries R/W
                  // Nine clocks for a written byte with its ack, eight for a read byte, one for an ack sequence
                  bit_q <= f_take ? 4'h8 : (recv_q ? 4'h8 : 4'h0);
                  scl_low_q <= 1'b1;
                  // Ack data clear means pull SDA low
                  sda_low_q <= f_take ? ~f_data[7] : (recv_q ? 1'b0 : ~ackdt_q);
                  brg_q <= reload_value_reg;
                  brg_run_q <= 1'b1;
                  st_q <= ST_BLOW;
               end
            end
            ST_SCHK: begin
               if (!scl_s_q) begin
                  bus_collision_irq_flag <= 1'b1;
                  start_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  st_q <= ST_IDLE;
               end else if (timeout && sda_s_q) begin
                  sda_low_q <= 1'b1;
                  s_bit_q <= 1'b1;
                  p_bit_q <= 1'b0;
                  brg_q <= reload_value_reg;
                  st_q <= ST_SLOW;
               end
            end
            ST_SLOW: begin
               if (timeout) begin
                  start_q <= 1'b0;
                  rstart_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  port_irq_flag <= 1'b1;
                  st_q <= ST_SHOLD;
               end
            end
            ST_SHOLD: begin
               // Pull SCL low holding SDA low; bus stays owned
               scl_low_q <= 1'b1;
               st_q <= ST_IDLE;
            end
            ST_BLOW: begin
               // Data moves one clock after SCL fell, never while SCL is high
               if (op_q == OP_TX) sda_low_q <= (bit_q == 4'h0) ? 1'b0 : ~sh_q[7];
               if (timeout) begin
                  scl_low_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  st_q <= ST_BHIGH;
               end
            end
            ST_BHIGH: begin
               if (!brg_run_q) begin
                  if (scl_s_q) begin
                     brg_q <= reload_value_reg;
                     brg_run_q <= 1'b1;
                  end
               end else if (timeout) begin
                  scl_low_q <= 1'b1;
                  brg_q <= reload_value_reg;
                  if (op_q == OP_RX) sh_q <= {sh_q[6:0], sda_s_q};
                  if (op_q == OP_TX && bit_q == 4'h0) begin
                     ack_received_flag_q <= sda_s_q;
                  end
                  if (bit_q == 4'h0 || (op_q == OP_RX && bit_q == 4'h0)) begin
                     brg_run_q <= 1'b0;
                     port_irq_flag <= 1'b1;
                     sda_low_q <= (op_q == OP_TX) ? 1'b0 : sda_low_q;
                     if (op_q == OP_RX) begin
                        rx_data <= {sh_q[6:0], sda_s_q};
                        rx_valid <= 1'b1;
                        recv_q <= 1'b0;
                     end
                     if (op_q == OP_ACK) ackseq_q <= 1'b0;
                     st_q <= ST_IDLE;
                  end else begin
                     bit_q <= bit_q - 4'h1;
                     if (op_q == OP_TX) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                     end
                     if (op_q == OP_RX && bit_q == 4'h1) begin
                        // Eighth bit done: byte complete, no ninth clock here
                        rx_data <= {sh_q[6:0], sda_s_q};
                        rx_valid <= 1'b1;
                        recv_q <= 1'b0;
                        port_irq_flag <= 1'b1;
                        brg_run_q <= 1'b0;
                        st_q <= ST_IDLE;
                     end else begin
                        st_q <= ST_BLOW;
                     end
                  end
               end
            end
            ST_RSREL: begin
               // Release SDA during low, then SCL, then start
               sda_low_q <= 1'b0;
               if (timeout) begin
                  scl_low_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  st_q <= ST_RSHI;
               end
            end
            ST_RSHI: begin
               if (!brg_run_q) begin
                  if (scl_s_q) begin
                     brg_q <= reload_value_reg;
                     brg_run_q <= 1'b1;
                  end
               end else if (!scl_s_q || !sda_s_q) begin
                  bus_collision_irq_flag <= 1'b1;
                  rstart_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  st_q <= ST_IDLE;
               end else if (timeout) begin
                  sda_low_q <= 1'b1;
                  s_bit_q <= 1'b1;
                  brg_q <= reload_value_reg;
                  st_q <= ST_SLOW;
               end
            end
            ST_PLOW: begin
               if (timeout) begin
                  scl_low_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  st_q <= ST_PHIGH;
               end
            end
            ST_PHIGH: begin
               if (!brg_run_q) begin
                  if (scl_s_q) begin
                     brg_q <= reload_value_reg;
                     brg_run_q <= 1'b1;
                  end
               end else if (timeout) begin
                  sda_low_q <= 1'b0;
                  brg_q <= reload_value_reg;
                  st_q <= ST_PDONE;
               end
            end
            ST_PDONE: begin
               if (timeout) begin
                  stop_q <= 1'b0;
                  brg_run_q <= 1'b0;
                  p_bit_q <= 1'b1;
                  s_bit_q <= 1'b0;
                  port_irq_flag <= 1'b1;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // i2c_master_start_and_baud

// ### tb/i2c_slave_model.sv
// Behavioural I2C slave on the open-drain bus
`timescale 1ns/1ns
module i2c_slave_model (
   // Bus lines
   input  wire logic       scl,
   input  wire logic       sda,
   // Behaviour
   input  wire logic       ack_en,
   input  wire logic       stretch,
   input  wire logic [7:0] tx_byte,
   // Pull-downs and last byte seen
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      got_byte
);
   integer     bit_n  = 0;
   integer     byte_n = 0;
   logic       rd     = 1'b0;
   logic [7:0] sr     = 8'h00;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      got_byte = 8'h00;
   end
   // Start restarts framing
   always @(negedge sda) if (scl === 1'b1) begin
      bit_n = 0;
      byte_n = 0;
      sda_pull = 1'b0;
   end
   // Sample on rising clock
   always @(posedge scl) begin
      if (bit_n < 8) sr = {sr[6:0], sda};
      bit_n = bit_n + 1;
   end
   // Drive on falling clock, ack or read data, optional stretch
   always @(negedge scl) begin
      if (bit_n >= 9) begin
         bit_n = 0;
         byte_n = byte_n + 1;
         sda_pull = 1'b0;
      end else if (bit_n == 8) begin
         got_byte = sr;
         if (byte_n == 0) rd = sr[0];
         sda_pull = (byte_n == 0 || !rd) && ack_en;
      end
      if (bit_n < 8 && byte_n == 1 && rd) sda_pull = !tx_byte[7 - bit_n];
      if (stretch) begin
         scl_pull = 1'b1;
         #300;
         scl_pull = 1'b0;
      end
   end
endmodule // i2c_slave_model

// ### tb/i2c_master_start_and_baud_monitor.sv
// Port-level checks for the I2C master engine
`timescale 1ns/1ns
`include "i2c_master_defs.vh"
module i2c_master_start_and_baud_monitor (
   // Clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // Requests and status
   input wire logic [6:0] reload_value_reg,
   input wire logic       cr2_we,
   input wire logic [7:0] cr2_wdata,
   input wire logic [7:0] control_reg_two,
   input wire logic       buf_we,
   input wire logic [7:0] port_status_reg,
   input wire logic       port_irq_flag,
   input wire logic       bus_collision_irq_flag,
   input wire logic       write_collision_flag,
   // Bus pins
   input wire logic       scl_in,
   input wire logic       scl_out,
   input wire logic       scl_oe,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe
);
   logic [15:0] high_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles SCL has read high while released
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) high_q <= 16'h0000;
      else if (!scl_in || scl_oe) high_q <= 16'h0000;
      else if (high_q != 16'hffff) high_q <= high_q + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Start steps, then pin, collision, lock, clock-high and hold checks
   sequence s_start_drive;
      $rose(sda_oe) && !scl_oe && control_reg_two[0];
   endsequence
   sequence s_start_end;
      $fell(control_reg_two[0]) && port_status_reg[3];
   endsequence
   property p_never_high;
      scl_out == 1'b0 && sda_out == 1'b0;
   endproperty
   property p_start_idle;
      s_start_drive |-> scl_in && $past(scl_in) && $past(sda_in);
   endproperty
   property p_start_seen;
      s_start_drive |-> ##[0:4] port_status_reg[3];
   endproperty
   property p_start_end;
      s_start_end |-> sda_oe ##[0:3] port_irq_flag;
   endproperty
   property p_collision;
      $rose(bus_collision_irq_flag) |-> ##[0:2] (!sda_oe && !scl_oe);
   endproperty
   property p_write_collision_flag;
      control_reg_two[0] && buf_we |=> write_collision_flag;
   endproperty
   property p_cr2_lock;
      control_reg_two[0] && cr2_we && cr2_wdata[2] |=> !control_reg_two[2];
   endproperty
   property p_scl_high;
      $rose(scl_oe) |-> high_q >= {8'h00, reload_value_reg, 1'b0};
   endproperty
   property p_hold;
      $rose(port_irq_flag) && scl_oe |=> $stable(scl_oe) [*3];
   endproperty
   a_never_high: assert property (p_never_high) else $error("pin driven high");
   a_start_idle: assert property (p_start_idle) else $error("start on busy bus");
   a_start_seen: assert property (p_start_seen) else $error("start bit late");
   a_start_end: assert property (p_start_end) else $error("start end wrong");
   a_collision: assert property (p_collision) else $error("lines held");
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("no write collision");
   a_cr2_lock: assert property (p_cr2_lock) else $error("stop taken");
   a_scl_high: assert property (p_scl_high) else $error("short high");
   a_hold: assert property (p_hold) else $error("clock moved");
endmodule // i2c_master_start_and_baud_monitor

bind i2c_master_start_and_baud i2c_master_start_and_baud_monitor mon_u (
   .clk, .arst_n, .reload_value_reg, .cr2_we, .cr2_wdata, .control_reg_two, .buf_we,
   .port_status_reg, .port_irq_flag, .bus_collision_irq_flag, .write_collision_flag,
   .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);

// ### tb/test_i2c_master_start_and_baud.sv
// Self-checking bench for the I2C master engine
`timescale 1ns/1ns
module test_i2c_master_start_and_baud;
   typedef struct {logic [6:0] rl; logic [7:0] adr; logic [7:0] dat; logic ack; logic str;} row_t;
   logic       clk = 1'b0, arst_n = 1'b0, cr2_we = 1'b0, buf_we = 1'b0, port_irq_clr = 1'b0;
   logic       bus_collision_clr = 1'b0, write_collision_clr = 1'b0;
   logic       tb_scl_low = 1'b0, tb_sda_low = 1'b0, ack_en = 1'b1, stretch = 1'b0;
   logic [6:0] reload_value_reg = 7'h00;
   logic [7:0] cr2_wdata = 8'h00, buf_wdata = 8'h00, slave_data = 8'h00, rx_seen = 8'h00;
   wire  [7:0] control_reg_two, rx_data, port_status_reg, got_byte;
   wire        buf_ready, rx_valid, port_irq_flag, bus_collision_irq_flag, write_collision_flag;
   wire        scl_out, scl_oe, sda_out, sda_oe, s_scl_pull, s_sda_pull;
   integer     n_mismatch = 0, compares = 0, r, i;
   row_t       rows [0:3] = '{'{7'h00, 8'ha4, 8'h3c, 1'b1, 1'b0},
      '{7'h01, 8'h5a, 8'hc3, 1'b1, 1'b1}, '{7'h03, 8'h7e, 8'h00, 1'b0, 1'b0},
      '{7'h7f, 8'h12, 8'h81, 1'b1, 1'b0}};
   // Open-drain lines with pull-ups
   wire        scl = !(scl_oe | s_scl_pull | tb_scl_low);
   wire        sda = !(sda_oe | s_sda_pull | tb_sda_low);
   i2c_master_start_and_baud #(.DEPTH(4)) dut_u (.clk, .arst_n, .reload_value_reg, .cr2_we,
      .cr2_wdata, .control_reg_two, .buf_we, .buf_wdata, .buf_ready, .rx_data, .rx_valid,
      .port_status_reg, .port_irq_flag, .port_irq_clr, .bus_collision_irq_flag,
      .bus_collision_clr, .write_collision_flag, .write_collision_clr, .scl_in(scl), .scl_out,
      .scl_oe, .sda_in(sda), .sda_out, .sda_oe);
   i2c_slave_model slave_u (.scl, .sda, .ack_en, .stretch, .tx_byte(slave_data),
      .scl_pull(s_scl_pull), .sda_pull(s_sda_pull), .got_byte);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, received byte capture, watchdog
   always #10 clk = ~clk;
   always @(posedge clk) if (rx_valid === 1'b1) rx_seen <= rx_data;
   initial begin
      #1_500_000;
      n_mismatch++;
      conclude;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cr2(input logic [7:0] v);
      @(posedge clk) begin cr2_we <= 1'b1; cr2_wdata <= v; end
      @(posedge clk) cr2_we <= 1'b0;
   endtask
   task put(input logic [7:0] v);
      @(posedge clk) begin buf_we <= 1'b1; buf_wdata <= v; end
      @(posedge clk) buf_we <= 1'b0;
   endtask
   task wait_irq;
      for (i = 0; i < 20000 && port_irq_flag !== 1'b1; i++) @(posedge clk);
      chk({7'h00, port_irq_flag}, 8'h01);
      @(posedge clk) port_irq_clr <= 1'b1;
      @(posedge clk) port_irq_clr <= 1'b0;
   endtask
   task wait_bcl;
      for (i = 0; i < 400 && bus_collision_irq_flag !== 1'b1; i++) @(posedge clk);
      chk({7'h00, bus_collision_irq_flag}, 8'h01);
      chk(control_reg_two & 8'h01, 8'h00);
      chk({6'h00, sda_oe, scl_oe}, 8'h00);
      @(posedge clk) begin tb_scl_low <= 1'b0; tb_sda_low <= 1'b0; bus_collision_clr <= 1'b1; end
      @(posedge clk) bus_collision_clr <= 1'b0;
   endtask
   task do_reset;
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(control_reg_two, 8'h00);
      chk(port_status_reg, 8'h00);
      chk({scl_oe, sda_oe, port_irq_flag, bus_collision_irq_flag, write_collision_flag,
           rx_valid, scl_out, sda_out}, 8'h00);
   endtask
   task conclude;
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      do_reset;
      for (r = 0; r < 4; r++) begin
         reload_value_reg <= rows[r].rl;
         ack_en <= rows[r].ack;
         stretch <= rows[r].str;
         cr2(8'h01);
         wait_irq;
         chk(port_status_reg & 8'h08, 8'h08);
         chk(control_reg_two & 8'h01, 8'h00);
         put(rows[r].adr);
         wait_irq;
         chk(got_byte, rows[r].adr);
         chk(control_reg_two & 8'h40, rows[r].ack ? 8'h00 : 8'h40);
         if (rows[r].ack) begin
            put(rows[r].dat);
            wait_irq;
            chk(got_byte, rows[r].dat);
         end
         cr2(8'h04);
         wait_irq;
         chk(port_status_reg & 8'h04, 8'h04);
      end
      // Early buffer write and stop request during a slow start
      reload_value_reg <= 7'h10;
      ack_en <= 1'b1;
      stretch <= 1'b0;
      slave_data <= 8'h6d;
      cr2(8'h01);
      put(8'h99);
      cr2(8'h04);
      @(negedge clk);
      chk(control_reg_two & 8'h04, 8'h00);
      chk({7'h00, write_collision_flag}, 8'h01);
      chk({7'h00, buf_ready}, 8'h00);
      wait_irq;
      chk(port_status_reg & 8'h01, 8'h00);
      @(posedge clk) write_collision_clr <= 1'b1;
      @(posedge clk) write_collision_clr <= 1'b0;
      // Single byte read, then nack, no stop before the repeated start
      put(8'h97);
      wait_irq;
      chk(control_reg_two & 8'h40, 8'h00);
      cr2(8'h08);
      wait_irq;
      chk(rx_seen, 8'h6d);
      cr2(8'h30);
      wait_irq;
      // Repeated start keeps the bus, then stop
      cr2(8'h02);
      wait_irq;
      chk(control_reg_two & 8'h02, 8'h00);
      chk({7'h00, scl_oe}, 8'h01);
      cr2(8'h04);
      wait_irq;
      // Both lines low at start request
      @(posedge clk) begin tb_scl_low <= 1'b1; tb_sda_low <= 1'b1; end
      cr2(8'h01);
      wait_bcl;
      // Clock pulled low before the data line falls
      cr2(8'h01);
      repeat (6) @(posedge clk);
      tb_scl_low <= 1'b1;
      wait_bcl;
      do_reset;
      conclude;
   end
endmodule // test_i2c_master_start_and_baud
